// [codec_regs_map.svh]
// offsets, field positions, reset values and timing counts of the channel register bank
`ifndef CODEC_REGS_MAP_SVH
`define CODEC_REGS_MAP_SVH
`define CMD_DEACT   8'h00
`define CMD_ACT     8'h0E
`define CMD_CR3     7'h30
`define CMD_CR4     7'h2A
`define CMD_CR5     7'h25
`define CMD_DBC     7'h64
`define CMD_PIN_WR  8'h52
`define CMD_PIN_RD  8'h53
`define CR3_RST     8'h00
`define CR5_RST     8'h0F
`define DBC_RST     8'h20
`define CR3_MU      6
`define CR4_CHANNEL_ACTIVE_FLAG   6
`define CR4_CLOCK_UNLOCKED_FLAG   5
`define CR5_IDLE_OUTPUT_MODE   5
`define CR5_LPM     4
`define DBC_EE1     7
`define DBC_E1P     6
`define DBC_DSH     5:2
`define DBC_ECH     0
`define SLOT_MON    2'h2
`define SLOT_SC     2'h3
`define MS_NS       1000000
`define MCLK_NS     4
`define CHOP_HALF   2'h3
`endif

// [codec_regs_pkg.sv]
// types shared by the channel register bank
package codec_regs_pkg;
  typedef enum logic [1:0] {PH_ADDR = 2'b00, PH_CMD = 2'b01, PH_DATA = 2'b10} mon_phase_t;
  typedef struct packed {
    logic [7:0][6:0] lvl;   // cd1,cd2,c3,c4,c5,c6,c7 per channel
    logic [7:0][6:0] oe_n;  // low while the pin is driven
  } line_out_t;
  typedef struct packed {
    logic [7:0]      mu_law;
    logic [7:0][5:0] filt_prog;  // rx gain, tx gain, x, r, z, b
    logic [7:0]      analog_voice_output_hiz;
    logic [7:0]      analog_voice_output_bias;
    logic            low_power;
    logic            e1_strobe;
    logic            chopper;
  } voice_ctl_t;
  typedef struct packed {
    logic dcl_s1, dcl_s2, dcl_d, fsc_s1, fsc_s2, fsc_d, dd_s1, dd_s2;
    logic [7:0][4:0]   pin_s1;
    logic [7:0][4:0]   pin_s2;
    logic [7:0]        bitcnt;
    logic [6:0]        sh;
    logic [7:0]        mon_tmp;
    logic              frame_odd;
    logic              du_bit;
    mon_phase_t [7:0]  phase;
    logic [7:0][7:0]   cmd;
    logic [7:0][7:0]   rep;
    logic [7:0]        rep_v;
    logic [7:0][7:0]   cr3;
    logic [7:0][4:0]   dir;
    logic [7:0]        channel_active_flag;
    logic [7:0][6:0]   pout;
    logic [7:0]        cr5;
    logic [7:0]        dbc;
    logic [7:0]        deb;
    logic [7:0]        cda;
    logic [7:0]        mux;
    logic [7:0][3:0]   dcnt;
    logic [17:0]       mscnt;
    logic [1:0]        chcnt;
    logic              chop;
  } st_t;
endpackage : codec_regs_pkg

// [channel_config_status_regs.sv]
// channel configuration and status registers reached over the serial monitor channel
`include "codec_regs_map.svh"
module channel_config_status_regs
  import codec_regs_pkg::*;
#(
  parameter int MS_CYCLES = `MS_NS / `MCLK_NS  // mclk cycles per millisecond
) (
  input  wire logic            mclk,       // device clock, 250 MHz
  input  wire logic            rst,        // async reset, active high
  input  wire logic            dcl,        // link bit clock pin
  input  wire logic            fsc,        // link frame sync pin
  input  wire logic            dd,         // downstream serial data pin
  output logic                 du_o,       // upstream data, open drain level
  output logic                 du_oe_n,    // low while pulling upstream low
  input  wire logic [7:0][4:0] pin_i,      // cd1,cd2,c3,c4,c5 levels per channel
  output line_out_t            pins,       // line pin drive
  input  wire logic            clk_locked, // internal clock locked to frame
  output voice_ctl_t           ctl         // voice path controls
);
  st_t st_reg, st_next;

  logic       dcl_rise, dcl_fall, fsc_rise, byte_done, ms_tick;
  logic [2:0] cur_ch;
  logic [1:0] cur_slot;
  logic [7:0] rx_byte;

  // level of every pin: driven value for outputs, synced pin for inputs
  function automatic logic [6:0] pin_lvl(st_t s, logic [2:0] c);
    logic [6:0] v;
    v = s.pout[c];
    for (int i = 0; i < 5; i++) begin
      if (!s.dir[c][i]) begin
        v[i] = s.pin_s2[c][i];
      end
    end
    return v;
  endfunction : pin_lvl

  // read data for a status command; bit 0 of cmd already known as read
  function automatic logic [7:0] rd_data(st_t s, logic [2:0] c, logic [7:0] cmd,
                                         logic unlocked);
    logic [6:0] l;
    l = pin_lvl(s, c);
    unique case (cmd[7:1])
      `CMD_CR3: rd_data = s.cr3[c];
      `CMD_CR4: rd_data = {1'b0, s.channel_active_flag[c], unlocked, s.dir[c]};
      `CMD_CR5: rd_data = s.cr5;
      `CMD_DBC: rd_data = s.dbc;
      // pin levels in fixed order, muxed_detector_bit valid only in E1 mode
      default:  rd_data = {l[6], l[5], s.mux[c], l[4], l[3], l[2], l[1], l[0]};
    endcase
  endfunction : rd_data

  // upstream byte for the current slot; B slots idle high
  function automatic logic [7:0] up_byte(st_t s, logic [2:0] c, logic [1:0] slot);
    logic [5:0] ci;
    logic       ee1;
    ee1 = s.dbc[`DBC_EE1];
    // detectors and c3 go upstream only while configured as inputs
    ci  = {s.dir[c][0] ? 1'b0 : (ee1 ? s.cda[c] : s.deb[c]),
           s.dir[c][1] ? 1'b0 : (ee1 ? s.mux[c] : s.pin_s2[c][1]),
           s.dir[c][2] ? 1'b0 : s.pin_s2[c][2], 3'h0};
    if (slot == `SLOT_MON) begin
      up_byte = s.rep_v[c] ? s.rep[c] : 8'hFF;
    end else if (slot == `SLOT_SC) begin
      up_byte = {ci, 1'b1, ~s.rep_v[c]};
    end else begin
      up_byte = 8'hFF;
    end
  endfunction : up_byte

  // edge finding on the synced link pins
  assign dcl_rise  = st_reg.dcl_s2 & ~st_reg.dcl_d;
  assign dcl_fall  = ~st_reg.dcl_s2 & st_reg.dcl_d;
  assign fsc_rise  = st_reg.fsc_s2 & ~st_reg.fsc_d;
  assign cur_ch    = st_reg.bitcnt[7:5];
  assign cur_slot  = st_reg.bitcnt[4:3];
  assign byte_done = dcl_fall & ~fsc_rise & (st_reg.bitcnt[2:0] == 3'h7);
  assign rx_byte   = {st_reg.sh, st_reg.dd_s2};
  assign ms_tick   = (st_reg.mscnt == 18'(MS_CYCLES - 1));

  // next-state logic for the whole bank
  always_comb begin
    logic [7:0] mb;
    logic [3:0] hook_debounce_period;
    logic [6:0] lv;
    logic [7:0] ub;
    logic [5:0] follow;
    mb     = st_reg.mon_tmp;
    hook_debounce_period    = st_reg.dbc[`DBC_DSH];
    lv     = '0;
    ub     = up_byte(st_reg, cur_ch, cur_slot);
    // c6 always follows C/I, detectors and c3..c5 only as outputs
    follow = {1'b1, st_reg.dir[cur_ch]};
    st_next = st_reg;
    // two-flop synchronisers, first stage read only by the second
    st_next.dcl_s1 = dcl;
    st_next.dcl_s2 = st_reg.dcl_s1;
    st_next.dcl_d  = st_reg.dcl_s2;
    st_next.fsc_s1 = fsc;
    st_next.fsc_s2 = st_reg.fsc_s1;
    st_next.fsc_d  = st_reg.fsc_s2;
    st_next.dd_s1  = dd;
    st_next.dd_s2  = st_reg.dd_s1;
    st_next.pin_s1 = pin_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.mscnt  = ms_tick ? 18'h0 : st_reg.mscnt + 18'h1;

    // debounce of detector one, period shared by all channels
    for (int c = 0; c < 8; c++) begin
      lv = pin_lvl(st_reg, 3'(c));
      if (lv[0] == st_reg.deb[c]) begin
        st_next.dcnt[c] = 4'h0;
      end else if (hook_debounce_period == 4'h0) begin
        st_next.deb[c] = ~st_reg.deb[c];
      end else if (ms_tick) begin
        if (st_reg.dcnt[c] == hook_debounce_period - 4'h1) begin
          st_next.deb[c]  = ~st_reg.deb[c];
          st_next.dcnt[c] = 4'h0;
        end else begin
          st_next.dcnt[c] = st_reg.dcnt[c] + 4'h1;
        end
      end
    end

    // chopper runs at bit clock over eight, only while enabled
    if (!st_reg.dbc[`DBC_ECH]) begin
      st_next.chop  = 1'b0;
      st_next.chcnt = 2'h0;
    end else if (dcl_rise) begin
      st_next.chcnt = st_reg.chcnt + 2'h1;
      if (st_reg.chcnt == `CHOP_HALF) begin
        st_next.chop = ~st_reg.chop;
      end
    end

    // upstream bit changes on the rising bit clock
    if (dcl_rise) begin
      st_next.du_bit = ub[3'h7 - st_reg.bitcnt[2:0]];
    end

    if (fsc_rise) begin
      st_next.bitcnt    = 8'h0;
      st_next.frame_odd = ~st_reg.frame_odd;
      // strobe frames feed the muxed bit, others the plain detector
      if (st_reg.dbc[`DBC_EE1]) begin
        for (int c = 0; c < 8; c++) begin
          if (st_reg.frame_odd) begin
            st_next.mux[c] = st_reg.deb[c];
          end else begin
            st_next.cda[c] = st_reg.deb[c];
          end
        end
      end
    end else if (dcl_fall) begin
      st_next.sh     = rx_byte[6:0];
      st_next.bitcnt = st_reg.bitcnt + 8'h1;
    end

    if (byte_done && cur_slot == `SLOT_MON) begin
      st_next.mon_tmp = rx_byte;
    end
    if (byte_done && cur_slot == `SLOT_SC) begin
      // reply went out this frame; a new one below wins over the clear
      st_next.rep_v[cur_ch] = 1'b0;
      // output pins follow downstream C/I; overrides an earlier 52h write except on c7, a 52h write in this byte wins
      for (int i = 0; i < 6; i++) begin
        if (follow[i]) begin
          st_next.pout[cur_ch][i] = rx_byte[i + 2];
        end
      end
      // monitor byte is taken when the downstream MX bit is low
      if (!rx_byte[0]) begin
        unique case (st_reg.phase[cur_ch])
          PH_ADDR: st_next.phase[cur_ch] = PH_CMD;
          PH_CMD: begin
            st_next.phase[cur_ch] = PH_ADDR;
            st_next.cmd[cur_ch]   = mb;
            // activate sets and deactivate clears the activity bit
            if (mb == `CMD_ACT) begin
              st_next.channel_active_flag[cur_ch] = 1'b1;
            end else if (mb == `CMD_DEACT) begin
              st_next.channel_active_flag[cur_ch] = 1'b0;
            // odd command reads, even command expects a data byte
            end else if (mb[0]) begin
              st_next.rep[cur_ch]   = rd_data(st_reg, cur_ch, mb, ~clk_locked);
              st_next.rep_v[cur_ch] = 1'b1;
            end else begin
              st_next.phase[cur_ch] = PH_DATA;
            end
          end
          PH_DATA: begin
            st_next.phase[cur_ch] = PH_ADDR;
            if (st_reg.cmd[cur_ch] == `CMD_PIN_WR) begin
              // pin write lands on output pins; c7 keeps it, the C/I-following pins only until next C/I
              st_next.pout[cur_ch] = {mb[7:6], mb[4:0]};
            end else begin
              unique case (st_reg.cmd[cur_ch][7:1])
                `CMD_CR3: st_next.cr3[cur_ch] = mb;
                // only the direction bits are writable
                `CMD_CR4: st_next.dir[cur_ch] = mb[4:0];
                // low-power bit stored, feeds nothing but the pin
                `CMD_CR5: st_next.cr5 = mb;
                `CMD_DBC: st_next.dbc = mb;
                default:  st_next.cr5 = st_reg.cr5;
              endcase
            end
          end
          default: st_next.phase[cur_ch] = PH_ADDR;
        endcase
      end
    end
  end

  // state register; reset loads documented defaults
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      // bit clock idles high; starting high avoids a false rise after reset
      st_reg.dcl_s1 <= 1'b1;
      st_reg.dcl_s2 <= 1'b1;
      st_reg.dcl_d  <= 1'b1;
      st_reg.cr5 <= `CR5_RST;
      // 8 ms debounce, E1 and chopper off
      st_reg.dbc <= `DBC_RST;
      for (int c = 0; c < 8; c++) begin
        st_reg.cr3[c] <= `CR3_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign du_o    = 1'b0;
  assign du_oe_n = st_reg.du_bit;
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      pins.lvl[c]  = st_reg.pout[c];
      pins.oe_n[c] = {2'h0, ~st_reg.dir[c]};
      ctl.mu_law[c]    = st_reg.cr3[c][`CR3_MU];
      ctl.filt_prog[c] = st_reg.cr3[c][5:0];
      // idle output handling follows the global mode bit
      ctl.analog_voice_output_hiz[c]  = ~st_reg.channel_active_flag[c] & st_reg.cr5[`CR5_IDLE_OUTPUT_MODE];
      ctl.analog_voice_output_bias[c] = ~st_reg.channel_active_flag[c] & ~st_reg.cr5[`CR5_IDLE_OUTPUT_MODE];
    end
    ctl.low_power = st_reg.cr5[`CR5_LPM];
    // strobe polarity; idle level is the inactive one
    ctl.e1_strobe = (st_reg.dbc[`DBC_EE1] & st_reg.frame_odd) ^ st_reg.dbc[`DBC_E1P];
    ctl.chopper   = st_reg.chop;
  end

  // checks on channel 0 and the global bits
  sequence s_cmd0(logic [7:0] code);
    byte_done && cur_slot == `SLOT_SC && cur_ch == 3'h0 && !rx_byte[0] &&
      st_reg.phase[0] == PH_CMD && st_reg.mon_tmp == code;
  endsequence

  chk_act_sets_stat: assert property (
    @(posedge mclk) disable iff (rst) s_cmd0(`CMD_ACT) |=> st_reg.channel_active_flag[0] ##1 ~ctl.analog_voice_output_bias[0])
    else $error("activate did not set channel activity");

  chk_deact_clrs_stat: assert property (
    @(posedge mclk) disable iff (rst) s_cmd0(`CMD_DEACT) |=> !st_reg.channel_active_flag[0])
    else $error("deactivate did not clear channel activity");

  chk_clock_unlocked_flag_global: assert property (
    @(posedge mclk) disable iff (rst)
      s_cmd0({`CMD_CR4, 1'b1}) |=> st_reg.rep_v[0] && st_reg.rep[0][`CR4_CLOCK_UNLOCKED_FLAG] == $past(~clk_locked))
    else $error("clock-fail bit does not reflect lock state");

  chk_cr5_reset: assert property (
    @(posedge mclk) disable iff (rst) $fell(rst) |-> st_reg.cr5 == 8'h0F)
    else $error("operating mode reset value wrong");

  chk_dbc_reset: assert property (
    @(posedge mclk) disable iff (rst) $fell(rst) |-> st_reg.dbc == 8'h20 && !ctl.chopper)
    else $error("debounce register reset value wrong");

  chk_deb_timing: assert property (
    @(posedge mclk) disable iff (rst)
      $changed(st_reg.deb[0]) |-> $past(ms_tick) || $past(st_reg.dbc[`DBC_DSH]) == 4'h0)
    else $error("debounced bit changed off the millisecond tick");

  chk_ci_drives_pin: assert property (
    @(posedge mclk) disable iff (rst)
      byte_done && cur_slot == `SLOT_SC && cur_ch == 3'h0 && st_reg.dir[0][0] &&
      !(!rx_byte[0] && st_reg.phase[0] == PH_DATA && st_reg.cmd[0] == `CMD_PIN_WR)
      |=> pins.lvl[0][0] == $past(rx_byte[2]) && !pins.oe_n[0][0])
    else $error("output pin did not follow downstream C/I");

  chk_chop_off: assert property (
    @(posedge mclk) disable iff (rst) !st_reg.dbc[`DBC_ECH] |=> !ctl.chopper)
    else $error("chopper running while disabled");

  chk_e1_idle: assert property (
    @(posedge mclk) disable iff (rst)
      !st_reg.dbc[`DBC_EE1] |-> ctl.e1_strobe == st_reg.dbc[`DBC_E1P])
    else $error("E1 strobe active while multiplexing off");
endmodule : channel_config_status_regs

// [gci_ctrl_model.sv]
// line-card controller model: drives link frames and collects the upstream frame
module gci_ctrl_model (
  output logic      dcl,     // link bit clock, still at high between frames
  output logic      fsc,     // frame sync
  output logic      dd,      // downstream data
  input  wire logic du_o,    // upstream level when pulled
  input  wire logic du_oe_n  // low while the device pulls upstream
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0][7:0] mon_dn;  // downstream monitor bytes
  logic [7:0]      mx_n;    // high marks a channel's monitor byte as empty
  logic [7:0][5:0] ci;      // downstream C/I bits
  logic [255:0]    up;      // last upstream frame, first bit at the top
  event            frame_done;
  // upstream wire has a pull-up, so a released line reads one
  wire du_line = du_oe_n ? 1'b1 : du_o;
  initial begin
    {dcl, fsc, dd} = 3'b101;
    mon_dn = '1;
    mx_n = '1;
    ci = '0;
  end
  // monitor byte and handshake bit in each channel slot
  task automatic frame();
    logic [255:0] dn;
    for (int c = 0; c < 8; c++) dn[255-32*c -: 32] = {16'hFFFF, mon_dn[c], ci[c], 1'b1, mx_n[c]};
    for (int i = 0; i < 256; i++) begin
      dcl = 1'b1;
      fsc = (i == 0);
      dd = dn[255-i];
      #16 dcl = 1'b0;
      #15 up[255-i] = du_line;
      #1;
    end
    {dcl, fsc, dd} = 3'b101;
    -> frame_done;
  endtask : frame
endmodule : gci_ctrl_model

// [test_channel_config_status_regs.sv]
// self-checking bench for the channel register bank over the serial link
module test_channel_config_status_regs;
  import codec_regs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {string what; logic [7:0] exp; logic [7:0] msk;} note_t;
  logic            mclk, rst, clk_locked, dcl, fsc, dd, du_o, du_oe_n;
  logic [7:0][4:0] pin_ext, pin_w, dir;
  logic [7:0][7:0] cmd, dat;
  line_out_t       pins;
  voice_ctl_t      ctl;
  note_t           notes[$];
  int              n_errors, checks_done, n_chop, n_e1;

  channel_config_status_regs #(.MS_CYCLES(20)) DUT (
    .mclk(mclk), .rst(rst), .dcl(dcl), .fsc(fsc), .dd(dd), .du_o(du_o), .du_oe_n(du_oe_n),
    .pin_i(pin_w), .pins(pins), .clk_locked(clk_locked), .ctl(ctl));
  gci_ctrl_model model (.dcl(dcl), .fsc(fsc), .dd(dd), .du_o(du_o), .du_oe_n(du_oe_n));

  // 250 MHz device clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // pin wire: device level where it drives, outside level otherwise
  always_comb begin
    for (int c = 0; c < 8; c++)
      pin_w[c] = (pin_ext[c] & pins.oe_n[c][4:0]) | (pins.lvl[c][4:0] & ~pins.oe_n[c][4:0]);
  end
  // transition counts prove the chopper and strobe outputs run
  always @(ctl.chopper) n_chop++;
  always @(ctl.e1_strobe) n_e1++;

  task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got, logic [7:0] msk);
    checks_done++;
    if (((got ^ exp) & msk) !== 8'h00) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp & msk, got & msk);
    end
  endtask : cmp8

  task automatic note(string what, logic [7:0] exp, logic [7:0] msk);
    notes.push_back('{what, exp, msk});
  endtask : note

  // address frame, command frame, then data frame or reply frame
  task automatic xfer(logic [7:0] en);
    model.mx_n = ~en;
    model.mon_dn = '0;
    model.frame();
    model.mon_dn = cmd;
    model.frame();
    // only even commands that carry data send a data byte
    for (int c = 0; c < 8; c++)
      model.mx_n[c] = !(en[c] && !cmd[c][0] && cmd[c] != 8'h00 && cmd[c] != 8'h0E);
    model.mon_dn = dat;
    model.frame();
    model.mx_n = '1;
    // let the last slot pass the synchronisers before outputs are compared
    repeat (6) @(posedge mclk);
  endtask : xfer

  task automatic end_of_test();
    if (notes.size() != 0) $display("unexpected replies: expected 0 seen %0d", notes.size());
    n_errors += notes.size();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // each upstream reply is matched against the oldest note, channels in slot order
  initial begin
    forever begin
      @(model.frame_done);
      for (int c = 0; c < 8; c++) begin
        if (model.up[224-32*c] === 1'b0) begin
          if (notes.size() == 0) begin
            n_errors++;
            $display("unexpected reply %0d: expected none seen %h", c, model.up[239-32*c -: 8]);
          end else begin
            note_t n;
            n = notes.pop_front();
            cmp8(n.what, n.exp, model.up[239-32*c -: 8], n.msk);
          end
        end
      end
    end
  end

  // watchdog well beyond the 21 frames of the run
  initial begin
    #300000;
    n_errors++;
    $display("unexpected timeout: expected finish seen none");
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    clk_locked = 1'b1;
    pin_ext = '0;
    cmd = '0;
    dat = '0;
    void'($urandom(32'hdc9940d9));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    pin_ext <= 40'({$urandom(), $urandom()});
    repeat (4) @(posedge mclk);
    n_chop = 0;
    n_e1 = 0;
    // reset values read back on several channels at once
    cmd[0] = 8'h61; note("cr3", 8'h00, 8'hFF);
    cmd[1] = 8'h4B; note("cr5", 8'h0F, 8'hFF);
    cmd[2] = 8'hC9; note("dbc", 8'h20, 8'hFF);
    cmd[3] = 8'h55; note("cr4", 8'h00, 8'h7F);
    cmd[4] = 8'h53; note("pin state", {3'b000, pin_ext[4]}, 8'hDF);
    cmd[5] = 8'h0E;
    cmd[6] = 8'h00;
    xfer(8'h7F);
    $display("reset read test done");
    // random coding bytes with the reserved bit written as zero
    for (int c = 0; c < 8; c++) begin
      dat[c] = 8'($urandom()) & 8'h7F;
      cmd[c] = 8'h60;
    end
    xfer(8'hFF);
    for (int c = 0; c < 8; c++) begin
      cmp8("coding", dat[c], {1'b0, ctl.mu_law[c], ctl.filt_prog[c]}, 8'h7F);
      cmp8("idle out", {7'h00, c != 5}, {6'h00, ctl.analog_voice_output_hiz[c], ctl.analog_voice_output_bias[c]}, 8'h03);
    end
    $display("coding write test done");
    // random directions and C/I bits, clock lock lost
    model.ci = 48'({$urandom(), $urandom()});
    @(posedge mclk) clk_locked <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      dir[c] = 5'($urandom());
      cmd[c] = 8'h54;
      dat[c] = {3'b000, dir[c]};
    end
    xfer(8'hFF);
    for (int c = 0; c < 8; c++) begin
      cmp8("pin enables", {3'b000, ~dir[c]}, {1'b0, pins.oe_n[c]}, 8'h7F);
      cmd[c] = 8'h55;
      note("cr4", {1'b0, c == 5, 1'b1, dir[c]}, 8'h7F);
    end
    xfer(8'hFF);
    for (int c = 0; c < 8; c++) begin
      cmp8("pin drive", {2'b00, model.ci[c]}, {1'b0, pins.lvl[c]}, {2'b00, 1'b1, dir[c]});
      cmp8("upstream ci", {~dir[c][0] & pin_ext[c][0], ~dir[c][1] & pin_ext[c][1],
        ~dir[c][2] & pin_ext[c][2], 5'b00010}, model.up[231-32*c -: 8], 8'hE3);
      cmd[c] = 8'h53;
      note("pin state", {1'b0, model.ci[c][5], 1'b0,
        (dir[c] & model.ci[c][4:0]) | (~dir[c] & pin_ext[c])}, 8'hDF);
    end
    xfer(8'hFF);
    cmp8("quiet outs", 8'h00, {6'h00, n_chop != 0, n_e1 != 0}, 8'h03);
    $display("direction test done");
    // pin write of c7; reserved bits zero in every written byte
    cmd[0] = 8'h52;
    dat[0] = 8'h80;
    cmd[1] = 8'h4A;
    dat[1] = 8'h30;
    cmd[2] = 8'hC8;
    dat[2] = 8'h81;
    xfer(8'h07);
    n_chop = 0;
    n_e1 = 0;
    for (int c = 0; c < 8; c++)
      cmp8("idle out", {6'h00, c != 5, 1'b0}, {6'h00, ctl.analog_voice_output_hiz[c], ctl.analog_voice_output_bias[c]}, 8'h03);
    cmd[0] = 8'h53; note("pin c7", 8'h80, 8'h80);
    cmd[3] = 8'hC9; note("dbc", 8'h81, 8'hFF);
    cmd[4] = 8'h4B; note("cr5", 8'h30, 8'hFF);
    xfer(8'h19);
    cmp8("running outs", 8'h03, {6'h00, n_chop > 4, n_e1 > 1}, 8'h03);
    $display("global mode test done");
    end_of_test();
  end
endmodule : test_channel_config_status_regs
